// File: include/tstf_pkg.sv
package tstf_pkg;
    localparam logic [7:0] C_STX  = 8'h02;
    localparam logic [7:0] C_ETX  = 8'h03;
    localparam logic [7:0] C_CR   = 8'h0d;
    localparam logic [7:0] C_LF   = 8'h0a;
    localparam logic [7:0] C_SP   = 8'h20;
    localparam logic [7:0] C_ZERO = 8'h30;
    localparam logic [7:0] C_FLD  = 8'h80;
    localparam int LEN_STD  = 32;
    localparam int LEN_GPS  = 36;
    localparam int LEN_CAP  = 31;
    localparam int LEN_SAT  = 29;
    localparam int LEN_LONG = 66;
    localparam int IDX_W    = 7;
    localparam int POS_STD_SEC = 24;
    localparam int POS_STD_U   = 27;
    localparam logic [11:0] A_CTRL = 12'h000;
    localparam logic [11:0] A_STAT = 12'h004;
    localparam logic [11:0] A_CNT  = 12'h008;
    localparam int CTRL_EN  = 0;
    localparam int CTRL_FMT = 1;
    localparam int STAT_BSY = 0;
    localparam int STAT_FMT = 1;
    localparam int STAT_IDX = 4;

    typedef enum logic [2:0] {
        FMT_STD  = 3'h0,
        FMT_GPS  = 3'h1,
        FMT_CAP  = 3'h2,
        FMT_SAT  = 3'h3,
        FMT_LONG = 3'h4
    } tstf_fmt_t;

    typedef struct packed {
        logic [7:0] day, mon, yr;
        logic [2:0] wday;
        logic [7:0] hr, min, sec;
    } tstf_time_t;

    typedef struct packed {
        logic       synced, pos_ok, utc, dst, ann_dst, ann_leap, leap_now, off_neg;
        logic [7:0] off_h, off_m;
        logic       leap_neg;
        logic [7:0] leap_cnt;
    } tstf_stat_t;

    typedef struct packed {
        logic [27:0] lat;
        logic        lat_s;
        logic [27:0] lon;
        logic        lon_w;
        logic [15:0] alt;
        logic        alt_neg;
    } tstf_pos_t;

    typedef struct packed {
        logic        ch;
        logic [27:0] frac;
        tstf_time_t  tm;
    } tstf_cap_t;

    function automatic logic [7:0] fc(input int k);
        return C_FLD | 8'(k);
    endfunction

    localparam logic [LEN_STD*8-1:0] TPL_STD = {C_STX, "D:", fc(0), fc(1), ".", fc(2), fc(3),
        ".", fc(4), fc(5), ";T:", fc(6), ";U:", fc(7), fc(8), ".", fc(9), fc(10), ".", fc(11),
        fc(12), ";", fc(13), fc(14), fc(15), fc(16), C_ETX};
    localparam logic [LEN_GPS*8-1:0] TPL_GPS = {C_STX, "D:", fc(0), fc(1), ".", fc(2), fc(3),
        ".", fc(4), fc(5), ";T:", fc(6), ";U:", fc(7), fc(8), ".", fc(9), fc(10), ".", fc(11),
        fc(12), ";", fc(13), fc(14), "G", fc(40), ";", fc(17), fc(18), fc(19), C_ETX};
    localparam logic [LEN_CAP*8-1:0] TPL_CAP = {"CH", fc(20), " ", fc(0), fc(1), ".", fc(2),
        fc(3), ".", fc(4), fc(5), " ", fc(7), fc(8), ":", fc(9), fc(10), ":", fc(11), fc(12),
        ".", fc(21), fc(22), fc(23), fc(24), fc(25), fc(26), fc(27), C_CR, C_LF};
    localparam logic [LEN_SAT*8-1:0] TPL_SAT = {C_STX, fc(0), fc(1), ".", fc(2), fc(3), ".",
        fc(4), fc(5), "/", fc(6), "/", fc(7), fc(8), ":", fc(9), fc(10), ":", fc(11), fc(12),
        fc(28), fc(29), fc(30), fc(31), fc(13), fc(39), C_CR, C_LF, C_ETX};
    localparam logic [LEN_LONG*8-1:0] TPL_LONG = {C_STX, fc(0), fc(1), ".", fc(2), fc(3), ".",
        fc(4), fc(5), "; ", fc(6), "; ", fc(7), fc(8), ":", fc(9), fc(10), ":", fc(11), fc(12),
        "; ", fc(33), fc(34), fc(35), ":", fc(36), fc(37), "; ", fc(13), fc(14), fc(38), fc(39),
        fc(40), " ", fc(41), ";", fc(42), fc(43), fc(44), ".", fc(45), fc(46), fc(47), fc(48),
        fc(49), " ", fc(50), fc(51), fc(52), ".", fc(53), fc(54), fc(55), fc(56), fc(57), " ",
        fc(58), fc(59), fc(60), fc(61), "m", C_ETX};
endpackage

// File: rtl/tstf_formatter.sv
// Our own choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
// Operation
// - Standard telegram is 32 characters from STX to ETX
// - STX is 02h and starts right at the second pulse
// - ETX closing byte is 03h
// - Template literals sent verbatim, fields filled from values latched at the trigger
// - Seconds show 60 during an inserted leap second
// - First status char is '#' unsynced, space once synced
// - Second status char is space once position known, else marker
// - Zone char 'U' for UTC, 'S' summer, space for winter
// - Announcement char active only in last hour before change
// - Satellite telegram is 36 characters framed by STX and ETX
// - Satellite telegram uses raw satellite time, zone char 'G'
// - Satellite telegram ends with leap second count before ETX
// - Capture telegram is 31 characters ending CR LF
// - Capture telegram names input 0 or 1, then a space
// - Capture time carries seven fraction digits
// - Compact telegram is 29 characters with UTC, CET or CEST
// - Long telegram is 66 characters framed by STX and ETX
// - Long telegram carries sign and UTC offset hours and minutes
// - Long leap flag active only in the inserted 60th second
// - Position leading zeros become spaces; N/S and E/W follow
// - Altitude is whole meters above the ellipsoid
module tstf_formatter
    import tstf_pkg::*;
#(
    parameter int CNT_W = 32
) (
    input  wire logic        i_clk,
    input  wire logic        i_srst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        i_pps,
    input  wire tstf_time_t  i_loc_time,
    input  wire tstf_time_t  i_gps_time,
    input  wire tstf_stat_t  i_stat,
    input  wire tstf_pos_t   i_pos,
    input  wire logic        i_cap_stb,
    input  wire tstf_cap_t   i_cap,
    output logic       [7:0] o_tx_data,
    output logic             o_tx_valid,
    input  wire logic        i_tx_ready
);
    if (CNT_W < 1 || CNT_W > 32) begin : g_chk
        $error("CNT_W must be 1..32");
    end

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_SEND = 2'b10
    } tstf_state_t;

    tstf_state_t      state;
    logic [IDX_W-1:0] idx;
    tstf_fmt_t        act_fmt;
    tstf_time_t       tm;
    tstf_stat_t       st;
    tstf_pos_t        pos;
    logic             cap_ch;
    logic [27:0]      cap_frac;
    logic             ctrl_en;
    tstf_fmt_t        ctrl_fmt;
    logic [CNT_W-1:0] count;
    logic             start;
    logic             fire;
    logic             last;
    logic             acc;

    function automatic logic [7:0] dig(input logic [3:0] d);
        return C_ZERO | {4'h0, d};
    endfunction

    // Lengths count both framing bytes of the framed telegrams and any CR LF trailer
    function automatic logic [IDX_W-1:0] len_of(input tstf_fmt_t f);
        case (f)
            FMT_STD:  return IDX_W'(LEN_STD);
            FMT_GPS:  return IDX_W'(LEN_GPS);
            FMT_CAP:  return IDX_W'(LEN_CAP);
            FMT_SAT:  return IDX_W'(LEN_SAT);
            default:  return IDX_W'(LEN_LONG);
        endcase
    endfunction

    function automatic logic [7:0] tpl_byte(input tstf_fmt_t f, input logic [IDX_W-1:0] i);
        int ii;
        ii = int'(i);
        case (f)
            FMT_STD:  return TPL_STD[(LEN_STD-1-ii)*8 +: 8];
            FMT_GPS:  return TPL_GPS[(LEN_GPS-1-ii)*8 +: 8];
            FMT_CAP:  return TPL_CAP[(LEN_CAP-1-ii)*8 +: 8];
            FMT_SAT:  return TPL_SAT[(LEN_SAT-1-ii)*8 +: 8];
            default:  return TPL_LONG[(LEN_LONG-1-ii)*8 +: 8];
        endcase
    endfunction

    // Field characters are built from the latched snapshot only
    function automatic logic [7:0] fchar(input logic [5:0] k);
        logic [7:0] c;
        c = C_SP;
        case (k)
            6'd0:  c = dig(tm.day[7:4]);
            6'd1:  c = dig(tm.day[3:0]);
            6'd2:  c = dig(tm.mon[7:4]);
            6'd3:  c = dig(tm.mon[3:0]);
            6'd4:  c = dig(tm.yr[7:4]);
            6'd5:  c = dig(tm.yr[3:0]);
            6'd6:  c = dig({1'b0, tm.wday});
            6'd7:  c = dig(tm.hr[7:4]);
            6'd8:  c = dig(tm.hr[3:0]);
            6'd9:  c = dig(tm.min[7:4]);
            6'd10: c = dig(tm.min[3:0]);
            6'd11: c = st.leap_now ? "6" : dig(tm.sec[7:4]);
            6'd12: c = st.leap_now ? "0" : dig(tm.sec[3:0]);
            6'd13: c = st.synced ? C_SP : "#";
            6'd14: c = st.pos_ok ? C_SP : "*";
            6'd15: c = st.utc ? "U" : (st.dst ? "S" : C_SP);
            6'd16: c = st.ann_dst ? "!" : (st.ann_leap ? "A" : C_SP);
            6'd17: c = st.leap_neg ? "-" : C_SP;
            6'd18: c = dig(st.leap_cnt[7:4]);
            6'd19: c = dig(st.leap_cnt[3:0]);
            6'd20: c = dig({3'h0, cap_ch});
            6'd21: c = dig(cap_frac[27:24]);
            6'd22: c = dig(cap_frac[23:20]);
            6'd23: c = dig(cap_frac[19:16]);
            6'd24: c = dig(cap_frac[15:12]);
            6'd25: c = dig(cap_frac[11:8]);
            6'd26: c = dig(cap_frac[7:4]);
            6'd27: c = dig(cap_frac[3:0]);
            6'd28: c = st.utc ? "U" : "C";
            6'd29: c = st.utc ? "T" : "E";
            // Zone name fills four columns; the three-letter names pad with a space
            6'd30: c = st.utc ? "C" : (st.dst ? "S" : "T");
            6'd31: c = (!st.utc && st.dst) ? "T" : C_SP;
            6'd32: c = C_SP;
            6'd33: c = st.off_neg ? "-" : "+";
            6'd34: c = dig(st.off_h[7:4]);
            6'd35: c = dig(st.off_h[3:0]);
            6'd36: c = dig(st.off_m[7:4]);
            6'd37: c = dig(st.off_m[3:0]);
            6'd38: c = (!st.utc && st.dst) ? "S" : C_SP;
            6'd39: c = st.ann_dst ? "!" : C_SP;
            6'd40: c = st.ann_leap ? "A" : C_SP;
            6'd41: c = st.leap_now ? "L" : C_SP;
            6'd42: c = (pos.lat[27:24] == 4'h0) ? C_SP : dig(pos.lat[27:24]);
            6'd43: c = (pos.lat[27:20] == 8'h00) ? C_SP : dig(pos.lat[23:20]);
            6'd44: c = dig(pos.lat[19:16]);
            6'd45: c = dig(pos.lat[15:12]);
            6'd46: c = dig(pos.lat[11:8]);
            6'd47: c = dig(pos.lat[7:4]);
            6'd48: c = dig(pos.lat[3:0]);
            6'd49: c = pos.lat_s ? "S" : "N";
            6'd50: c = (pos.lon[27:24] == 4'h0) ? C_SP : dig(pos.lon[27:24]);
            6'd51: c = (pos.lon[27:20] == 8'h00) ? C_SP : dig(pos.lon[23:20]);
            6'd52: c = dig(pos.lon[19:16]);
            6'd53: c = dig(pos.lon[15:12]);
            6'd54: c = dig(pos.lon[11:8]);
            6'd55: c = dig(pos.lon[7:4]);
            6'd56: c = dig(pos.lon[3:0]);
            6'd57: c = pos.lon_w ? "W" : "E";
            // Negative altitude takes the first column, so only three digits remain
            6'd58: c = pos.alt_neg ? "-"
                     : ((pos.alt[15:12] == 4'h0) ? C_SP : dig(pos.alt[15:12]));
            6'd59: c = (pos.alt[15:8] == 8'h00) ? C_SP : dig(pos.alt[11:8]);
            6'd60: c = (pos.alt[15:4] == 12'h000) ? C_SP : dig(pos.alt[7:4]);
            6'd61: c = dig(pos.alt[3:0]);
            default: c = C_SP;
        endcase
        return c;
    endfunction

    function automatic logic [7:0] char_at(input tstf_fmt_t f, input logic [IDX_W-1:0] i);
        logic [7:0] b;
        b = tpl_byte(f, i);
        return b[7] ? fchar(b[5:0]) : b;
    endfunction

    assign o_tx_valid = (state == ST_SEND);
    assign fire       = o_tx_valid && i_tx_ready;
    assign last       = (idx == len_of(act_fmt) - IDX_W'(1));
    // Capture telegrams follow the capture strobe; all others ride the second pulse
    assign start      = (state == ST_IDLE) && ctrl_en && (ctrl_fmt <= FMT_LONG)
                      && ((ctrl_fmt == FMT_CAP) ? i_cap_stb : i_pps);

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            state <= ST_IDLE;
            idx   <= '0;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (start) begin
                        state <= ST_SEND;
                        idx   <= '0;
                    end
                end
                ST_SEND: begin
                    if (fire) begin
                        if (last) begin
                            state <= ST_IDLE;
                        end else begin
                            idx <= idx + IDX_W'(1);
                        end
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // Snapshot keeps one telegram self-consistent even if the core ticks mid-frame
    // Position and capture fields are latched for every format; unused ones cost only flops
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            act_fmt  <= FMT_STD;
            tm       <= '0;
            st       <= '0;
            pos      <= '0;
            cap_ch   <= 1'b0;
            cap_frac <= '0;
        end else if (start) begin
            act_fmt  <= ctrl_fmt;
            pos      <= i_pos;
            st       <= i_stat;
            cap_ch   <= i_cap.ch;
            cap_frac <= i_cap.frac;
            case (ctrl_fmt)
                FMT_GPS: tm <= i_gps_time;
                FMT_CAP: tm <= i_cap.tm;
                default: tm <= i_loc_time;
            endcase
        end
    end

    // First character comes from the template alone, so it is ready one cycle after the pulse
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_tx_data <= C_SP;
        end else if (start) begin
            o_tx_data <= tpl_byte(ctrl_fmt, '0);
        end else if (fire && !last) begin
            o_tx_data <= char_at(act_fmt, idx + IDX_W'(1));
        end
    end

    // Counter wraps silently; software takes differences, not absolutes
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            count <= '0;
        end else if (fire && last) begin
            count <= count + CNT_W'(1);
        end
    end

    // Zero-wait APB slave; unmapped addresses answer with an error
    assign pready = 1'b1;
    assign acc    = psel && penable;

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            ctrl_en  <= 1'b0;
            ctrl_fmt <= FMT_STD;
        end else if (acc && pwrite && paddr == A_CTRL) begin
            ctrl_en  <= pwdata[CTRL_EN];
            ctrl_fmt <= tstf_fmt_t'(pwdata[CTRL_FMT +: 3]);
        end
    end

    // Status reads are side-effect free, so polling cannot disturb a telegram
    always_comb begin
        prdata  = '0;
        pslverr = 1'b0;
        if (acc) begin
            case (paddr)
                A_CTRL: begin
                    prdata[CTRL_EN]        = ctrl_en;
                    prdata[CTRL_FMT +: 3]  = ctrl_fmt;
                end
                A_STAT: begin
                    prdata[STAT_BSY]       = o_tx_valid;
                    prdata[STAT_FMT +: 3]  = act_fmt;
                    prdata[STAT_IDX +: IDX_W] = idx;
                end
                A_CNT: prdata[CNT_W-1:0] = count;
                default: pslverr = 1'b1;
            endcase
        end
    end

    // Checks
    logic [IDX_W-1:0] nchr;
    always_ff @(posedge i_clk) begin
        if (i_srst || start) begin
            nchr <= '0;
        end else if (fire) begin
            nchr <= nchr + IDX_W'(1);
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_srst);

    // Positions count from the first byte of the telegram at index zero
    frame_len_a: assert property (
        fire && o_tx_data == C_ETX |-> nchr + IDX_W'(1) == len_of(act_fmt))
        else $error("ETX at wrong count");

    etx_end_a: assert property (
        fire && last && act_fmt != FMT_CAP |-> o_tx_data == C_ETX)
        else $error("Telegram not ended by ETX");

    stx_first_a: assert property (
        start && ctrl_fmt != FMT_CAP |=> o_tx_valid && o_tx_data == C_STX)
        else $error("No STX after pulse");

    cap_first_a: assert property (
        start && ctrl_fmt == FMT_CAP |=> o_tx_valid && o_tx_data == "C")
        else $error("Capture telegram start wrong");

    cap_crlf_a: assert property (
        fire && act_fmt == FMT_CAP && idx == IDX_W'(LEN_CAP-2)
        |-> o_tx_data == C_CR ##1 o_tx_data == C_LF)
        else $error("Capture end wrong");

    tx_hold_a: assert property (
        o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_data) && $stable(idx))
        else $error("Char dropped");

    valid_drop_a: assert property (
        fire && last |=> !o_tx_valid)
        else $error("Offer after last char");

    count_step_a: assert property (
        fire && last |=> count == $past(count) + CNT_W'(1))
        else $error("Telegram count wrong");

    fmt_stable_a: assert property (
        o_tx_valid && !(fire && last) |=> $stable(act_fmt) && $stable(tm))
        else $error("Snapshot changed mid frame");

    sec_leap_a: assert property (
        fire && act_fmt == FMT_STD && idx == IDX_W'(POS_STD_SEC-1) && st.leap_now
        |=> o_tx_data == "6")
        else $error("Leap second not 60");

    sync_char_a: assert property (
        fire && act_fmt == FMT_STD && idx == IDX_W'(POS_STD_U-1)
        |=> o_tx_data == (st.synced ? C_SP : "#"))
        else $error("Sync char wrong");

    zone_std_a: assert property (
        fire && act_fmt == FMT_STD && idx == IDX_W'(POS_STD_U+1)
        |=> o_tx_data == (st.utc ? "U" : (st.dst ? "S" : C_SP)))
        else $error("Zone char wrong");

    zone_name_a: assert property (
        act_fmt == FMT_SAT && !st.utc && st.dst |-> fchar(6'd30) == "S" && fchar(6'd31) == "T")
        else $error("Summer zone name wrong");

    idle_quiet_a: assert property (
        !o_tx_valid && !start |=> !o_tx_valid)
        else $error("Send without trigger");

    std_done_c: cover property (fire && last && act_fmt == FMT_STD);
    gps_done_c: cover property (fire && last && act_fmt == FMT_GPS);
    cap_done_c: cover property (fire && last && act_fmt == FMT_CAP);
    long_done_c: cover property (fire && last && act_fmt == FMT_LONG);
    stall_c: cover property (o_tx_valid && !i_tx_ready ##1 fire);
endmodule // tstf_formatter

// File: tb/tstf_tx_model.sv
`timescale 1ns/1ps
// Byte-serial transmitter: takes one character per handshake, then may stay busy
// for a random character time so the formatter has to hold its offer
module tstf_tx_model (
    input  wire logic       i_clk,
    input  wire logic       i_srst,
    input  wire logic [7:0] i_tx_data,
    input  wire logic       i_tx_valid,
    input  wire logic       i_slow,
    output logic            o_tx_ready
);
    logic [2:0] busy_cnt;
    logic [7:0] shift_reg;

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_tx_ready <= 1'b0;
            busy_cnt   <= 3'h0;
            shift_reg  <= 8'h00;
        end else if (o_tx_ready && i_tx_valid) begin
            shift_reg  <= i_tx_data;
            o_tx_ready <= !i_slow;
            busy_cnt   <= 3'($urandom_range(6));
        end else if (busy_cnt != 3'h0) begin
            busy_cnt <= busy_cnt - 3'h1;
        end else begin
            o_tx_ready <= 1'b1;
        end
    end
endmodule // tstf_tx_model

// File: tb/serial_time_telegram_formatter_test.sv
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin mismatches++; \
    $display("FAIL %s expected %h seen %h", nm, ex, got); end end
module serial_time_telegram_formatter_test
    import tstf_pkg::*;
();
    logic        i_clk = 1'b0, i_srst = 1'b1, i_pps = 1'b0, i_cap_stb = 1'b0, slow = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, er, tx_valid, tx_ready;
    logic [7:0]  tx_data, e;
    tstf_time_t  lt = '0, gt = '0;
    tstf_stat_t  st = '0;
    tstf_pos_t   pos = '0;
    tstf_cap_t   cap = '0;
    logic [7:0]  q[$];
    int          mismatches = 0, tests_run = 0, ntel = 0;

    always #5 i_clk = ~i_clk;

    tstf_formatter DUT (.i_clk(i_clk), .i_srst(i_srst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .i_pps(i_pps), .i_loc_time(lt), .i_gps_time(gt), .i_stat(st),
        .i_pos(pos), .i_cap_stb(i_cap_stb), .i_cap(cap), .o_tx_data(tx_data),
        .o_tx_valid(tx_valid), .i_tx_ready(tx_ready));
    tstf_tx_model partner (.i_clk(i_clk), .i_srst(i_srst), .i_tx_data(tx_data),
        .i_tx_valid(tx_valid), .i_slow(slow), .o_tx_ready(tx_ready));

    // Each accepted character is matched against the oldest expected one
    always @(posedge i_clk) begin
        if (!i_srst && tx_valid === 1'b1 && tx_ready === 1'b1) begin
            e = (q.size() != 0) ? q.pop_front() : 8'hxx;
            `CHK("char", e, tx_data)
        end
    end

    task automatic test_done();
        $display("Checks %0d, mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic hang(string nm);
        mismatches++;
        $display("FAIL %s expected done seen timeout", nm);
        test_done();
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge i_clk);
        psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge i_clk);
        penable <= 1'b1;
        n = 0;
        do begin @(posedge i_clk); n++; end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        if (n >= 50) hang("apb");
    endtask

    function automatic logic [7:0] rb(int lo, int hi);
        int d;
        d = $urandom_range(hi, lo);
        return {4'(d / 10), 4'(d % 10)};
    endfunction
    function automatic tstf_time_t rt();
        return {rb(1, 28), rb(1, 12), rb(0, 99), 3'(rb(1, 7)), rb(0, 23), rb(0, 59), rb(0, 59)};
    endfunction
    function automatic string pk(logic c, string a, string b);
        return c ? a : b;
    endfunction
    function automatic string b2(logic [7:0] v);
        return $sformatf("%02h", v);
    endfunction
    function automatic string dt(tstf_time_t t);
        return {b2(t.day), ".", b2(t.mon), ".", b2(t.yr)};
    endfunction
    function automatic string wd(tstf_time_t t);
        return $sformatf("%0d", t.wday);
    endfunction
    function automatic string tm(tstf_time_t t, logic lp, string sp);
        return {b2(t.hr), sp, b2(t.min), sp, pk(lp, "60", b2(t.sec))};
    endfunction
    function automatic string lz(string s);
        for (int i = 0; i < s.len() - 1; i++) begin
            if (s[i] != 8'h30) break;
            s[i] = 8'h20;
        end
        return s;
    endfunction

    function automatic string mk(int f);
        string u, v, la, lo;
        u = pk(st.synced, " ", "#");
        v = pk(st.pos_ok, " ", "*");
        la = $sformatf("%07h", pos.lat);
        lo = $sformatf("%07h", pos.lon);
        case (f)
            0: return {"\002D:", dt(lt), ";T:", wd(lt), ";U:", tm(lt, st.leap_now, "."), ";", u, v,
                pk(st.utc, "U", pk(st.dst, "S", " ")),
                pk(st.ann_dst, "!", pk(st.ann_leap, "A", " ")), "\003"};
            1: return {"\002D:", dt(gt), ";T:", wd(gt), ";U:", tm(gt, 1'b0, "."), ";", u, v, "G",
                pk(st.ann_leap, "A", " "), ";", pk(st.leap_neg, "-", " "),
                b2(st.leap_cnt), "\003"};
            2: return {"CH", pk(cap.ch, "1", "0"), " ", dt(cap.tm), " ",
                tm(cap.tm, 1'b0, ":"), ".", $sformatf("%07h", cap.frac),
                "\015\012"};
            3: return {"\002", dt(lt), "/", wd(lt), "/", tm(lt, st.leap_now, ":"),
                pk(st.utc, "UTC ", pk(st.dst, "CEST", "CET ")), u,
                pk(st.ann_dst, "!", " "), "\015\012\003"};
            4: return {"\002", dt(lt), "; ", wd(lt), "; ", tm(lt, st.leap_now, ":"), "; ",
                pk(st.off_neg, "-", "+"), b2(st.off_h), ":", b2(st.off_m), "; ", u, v,
                pk(st.dst, "S", " "), pk(st.ann_dst, "!", " "), pk(st.ann_leap, "A", " "), " ",
                pk(st.leap_now, "L", " "), ";",
                lz(la.substr(0, 2)), ".", la.substr(3, 6),
                pk(pos.lat_s, "S", "N"), " ", lz(lo.substr(0, 2)), ".", lo.substr(3, 6),
                pk(pos.lon_w, "W", "E"), " ", lz($sformatf("%04h", pos.alt)),
                "m\003"};
            default: return "";
        endcase
    endfunction

    task automatic push(string s);
        for (int i = 0; i < s.len(); i++) q.push_back(s[i]);
    endtask

    // Time inputs are scrambled right after the trigger: the telegram must not follow them
    task automatic fire(logic c);
        logic [7:0] first;
        first = q[0];
        @(posedge i_clk);
        if (c) i_cap_stb <= 1'b1;
        else i_pps <= 1'b1;
        @(posedge i_clk);
        i_cap_stb <= 1'b0; i_pps <= 1'b0; lt <= rt(); gt <= rt(); cap.tm <= rt();
        #1;
        `CHK("first char", first, tx_data)
        `CHK("first valid", 1'b1, tx_valid)
    endtask

    task automatic wait_done();
        int n;
        n = 0;
        while ((q.size() != 0 || tx_valid !== 1'b0) && n < 3000) begin
            @(posedge i_clk);
            n++;
        end
        if (n >= 3000) hang("telegram");
        ntel++;
    endtask

    // Both triggers pulse while the given setting must keep the formatter quiet
    task automatic quiet(input logic [31:0] c, input string nm);
        apb(1'b1, A_CTRL, c);
        @(posedge i_clk);
        i_pps <= 1'b1;
        i_cap_stb <= 1'b1;
        @(posedge i_clk);
        i_pps <= 1'b0;
        i_cap_stb <= 1'b0;
        repeat (3) @(posedge i_clk);
        `CHK(nm, 1'b0, tx_valid)
    endtask

    task automatic run(int f, int rep);
        tstf_stat_t s;
        s = {rep == 1 ? 8'hff : (rep == 0 ? 8'h00 : 8'($urandom)), rb(0, 13),
             rep[0] ? 8'h30 : 8'h00, 1'(rep != 0), rb(0, 37)};
        if (s.utc) s.dst = 1'b0;
        if (f == 1 || f == 2) s.leap_now = 1'b0;
        @(posedge i_clk);
        st <= s; lt <= rt(); gt <= rt(); slow <= rep[0];
        cap <= {1'($urandom_range(1)), 4'($urandom_range(9)), rb(0, 99), rb(0, 99), rb(0, 99), rt()};
        pos <= rep == 1 ? {28'h1230000, 1'b1, 28'h0012345, 1'b1, 16'h1234, 1'b0}
                        : {28'h0481234, 1'b0, 28'h0115678, 1'b0, 16'h0050, 1'b0};
        apb(1'b1, A_CTRL, (32'(f) << CTRL_FMT) | 32'h1);
        push(mk(f));
        fire(f == 2);
        wait_done();
    endtask

    initial begin
        void'($urandom(32'hf9b6));
        repeat (3) @(posedge i_clk);
        i_srst <= 1'b0;
        #1;
        `CHK("reset valid", 1'b0, tx_valid)
        `CHK("reset data", 8'h20, tx_data)
        apb(1'b1, 12'hffc, 32'hffff_ffff);
        `CHK("unmapped err", 1'b1, er)
        apb(1'b0, A_CTRL, 32'h0);
        `CHK("ctrl reset", 32'h0, rd)
        for (int rep = 0; rep < 3; rep++)
            for (int f = 0; f < 5; f++) run(f, rep);
        // A trigger during a telegram must be lost, and a format change must wait for the next telegram
        run(0, 2);
        push(mk(0));
        apb(1'b1, A_CTRL, 32'h1);
        fire(1'b0);
        for (int n = 0; q.size() > 20; n++) begin
            if (n >= 3000) hang("drain");
            @(posedge i_clk);
        end
        apb(1'b1, A_CTRL, (32'h3 << CTRL_FMT) | 32'h1);
        @(posedge i_clk);
        i_pps <= 1'b1;
        @(posedge i_clk);
        i_pps <= 1'b0;
        apb(1'b0, A_STAT, 32'h0);
        `CHK("busy", 1'b1, rd[STAT_BSY])
        `CHK("active format", 3'h0, rd[STAT_FMT+:3])
        wait_done();
        push(mk(3));
        fire(1'b0);
        wait_done();
        quiet(32'h0, "disabled idle");
        quiet((32'h5 << CTRL_FMT) | 32'h1, "reserved idle");
        q.delete();
        apb(1'b0, A_CNT, 32'h0);
        `CHK("telegram count", 32'(ntel), rd)
        test_done();
    end
endmodule // serial_time_telegram_formatter_test
